// ==== design/ipb_pkg.sv ====
// shared constants and types for the interrupt priority bank
package ipb_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int IPB_NREG   = 5;
    localparam int IPB_NSRC   = 19;
    localparam int IPB_LVL_W  = 3;
    localparam int IPB_REG_W  = 16;
    localparam int IPB_ADDR_W = 8;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [IPB_ADDR_W-1:0] IPB_OFS_CAPTURE_DMA    = 8'h00;
    localparam logic [IPB_ADDR_W-1:0] IPB_OFS_COMPARE_CAPT   = 8'h04;
    localparam logic [IPB_ADDR_W-1:0] IPB_OFS_TIMER_DMA_CMP  = 8'h08;
    localparam logic [IPB_ADDR_W-1:0] IPB_OFS_TIMER_TWOWIRE  = 8'h0C;
    localparam logic [IPB_ADDR_W-1:0] IPB_OFS_CAN_EXTINT_TMR = 8'h10;
    localparam logic [2:0]            IPB_IDX_NONE           = 3'h7;

    // ************************************************************
    // field values, masks and reset words
    // ************************************************************
    localparam logic [2:0]  IPB_LEVEL_RESET  = 3'h4;
    localparam logic [2:0]  IPB_LEVEL_OFF    = 3'h0;
    localparam logic [15:0] IPB_MASK_FULL    = 16'h7777;
    localparam logic [15:0] IPB_MASK_NO_MID  = 16'h7707;
    localparam logic [15:0] IPB_RESET_FULL   = {4{1'b0, IPB_LEVEL_RESET}};
    localparam logic [15:0] IPB_RESET_NO_MID = IPB_RESET_FULL & IPB_MASK_NO_MID;
    localparam logic [15:0] IPB_MASK [IPB_NREG] =
        '{IPB_MASK_FULL, IPB_MASK_FULL, IPB_MASK_NO_MID, IPB_MASK_FULL, IPB_MASK_FULL};
    localparam logic [15:0] IPB_RESET [IPB_NREG] =
        '{IPB_RESET_FULL, IPB_RESET_FULL, IPB_RESET_NO_MID, IPB_RESET_FULL, IPB_RESET_FULL};

    localparam logic [1:0] IPB_RESP_OKAY   = 2'h0;
    localparam logic [1:0] IPB_RESP_SLVERR = 2'h2;

    // ************************************************************
    // interrupt sources: holding register and field position
    // ************************************************************
    typedef enum int {
        IPB_SRC_CAPTURE5, IPB_SRC_CAPTURE4, IPB_SRC_CAPTURE3, IPB_SRC_DMA3_DONE,
        IPB_SRC_COMPARE7, IPB_SRC_COMPARE6, IPB_SRC_COMPARE5, IPB_SRC_CAPTURE6,
        IPB_SRC_TIMER6, IPB_SRC_DMA4_DONE, IPB_SRC_COMPARE8,
        IPB_SRC_TIMER8, IPB_SRC_TWOWIRE2_MASTER, IPB_SRC_TWOWIRE2_SLAVE, IPB_SRC_TIMER7,
        IPB_SRC_CAN2_RECEIVE, IPB_SRC_EXTERNAL4, IPB_SRC_EXTERNAL3, IPB_SRC_TIMER9
    } ipb_src_e;

    localparam int IPB_SRC_REG [IPB_NSRC] =
        '{0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 3, 3, 3, 3, 4, 4, 4, 4};
    localparam int IPB_SRC_LSB [IPB_NSRC] =
        '{12, 8, 4, 0, 12, 8, 4, 0, 12, 8, 0, 12, 8, 4, 0, 12, 8, 4, 0};

    // ************************************************************
    // types
    // ************************************************************
    typedef logic [IPB_REG_W-1:0]             ipb_word_t;
    typedef ipb_word_t [IPB_NREG-1:0]         ipb_bank_t;
    typedef logic [IPB_LVL_W-1:0]             ipb_level_t;
    typedef ipb_level_t [IPB_NSRC-1:0]        ipb_levels_t;
    typedef enum logic {IPB_WR_COLLECT, IPB_WR_RESP} ipb_wr_state_t;
    typedef enum logic {IPB_RD_IDLE, IPB_RD_DATA}    ipb_rd_state_t;

    typedef struct packed {
        logic [1:0]  resp;
        logic [31:0] data;
    } ipb_rd_beat_t;

endpackage : ipb_pkg

// ==== design/ipb_prio_reg.sv ====
// one 16-bit priority register with byte lanes and fixed-zero holes
`timescale 1ns/1ps
module ipb_prio_reg
    import ipb_pkg::*;
#(
    parameter logic [15:0] MASK  = IPB_MASK_FULL,
    parameter logic [15:0] RESET = IPB_RESET_FULL
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       wr_i,
    input  wire logic [1:0] strb_i,
    input  wire logic [15:0] wdata_i,
    output ipb_word_t       value_o
);

    ipb_word_t next_value;

    // holes are masked on the way in, so they can never read back as one
    assign next_value = {strb_i[1] ? wdata_i[15:8] : value_o[15:8],
                         strb_i[0] ? wdata_i[7:0]  : value_o[7:0]} & MASK;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            value_o <= RESET;
        end else if (wr_i) begin
            value_o <= next_value;
        end
    end

endmodule : ipb_prio_reg

// ==== design/ipb_level_map.sv ====
// slices the bank into per-source levels and gates requests
`timescale 1ns/1ps
module ipb_level_map
    import ipb_pkg::*;
(
    input  wire ipb_bank_t            bank_i,
    input  wire logic [IPB_NSRC-1:0]  flag_i,
    output ipb_levels_t               level_o,
    output logic [IPB_NSRC-1:0]       req_o
);

    for (genvar s = 0; s < IPB_NSRC; s++) begin : g_src
        // straight binary: 7 highest, 1 lowest active
        assign level_o[s] = bank_i[IPB_SRC_REG[s]][IPB_SRC_LSB[s] +: IPB_LVL_W];
        assign req_o[s]   = flag_i[s] && (level_o[s] != IPB_LEVEL_OFF);
    end

endmodule : ipb_level_map

// ==== design/ipb_bank_top.sv ====
// interrupt priority bank: AXI4-Lite registers and level outputs
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module ipb_bank_top
    import ipb_pkg::*;
(
    input  wire logic                  CLK_I,
    input  wire logic                  RST_N_I,
    input  wire logic [IPB_ADDR_W-1:0] S_AXI_AWADDR_I,
    input  wire logic                  S_AXI_AWVALID_I,
    output logic                       S_AXI_AWREADY_O,
    input  wire logic [31:0]           S_AXI_WDATA_I,
    input  wire logic [3:0]            S_AXI_WSTRB_I,
    input  wire logic                  S_AXI_WVALID_I,
    output logic                       S_AXI_WREADY_O,
    output logic [1:0]                 S_AXI_BRESP_O,
    output logic                       S_AXI_BVALID_O,
    input  wire logic                  S_AXI_BREADY_I,
    input  wire logic [IPB_ADDR_W-1:0] S_AXI_ARADDR_I,
    input  wire logic                  S_AXI_ARVALID_I,
    output logic                       S_AXI_ARREADY_O,
    output logic [31:0]                S_AXI_RDATA_O,
    output logic [1:0]                 S_AXI_RRESP_O,
    output logic                       S_AXI_RVALID_O,
    input  wire logic                  S_AXI_RREADY_I,
    input  wire logic [IPB_NSRC-1:0]   SRC_FLAG_I,
    output ipb_levels_t                SRC_LEVEL_O,
    output logic [IPB_NSRC-1:0]        SRC_REQ_O
);

    // ************************************************************
    // address decode
    // ************************************************************
    // low two address bits are ignored: every register is one word
    function automatic logic [2:0] reg_index(input logic [IPB_ADDR_W-1:0] a);
        logic [IPB_ADDR_W-1:0] w;
        w = {a[IPB_ADDR_W-1:2], 2'b00};
        if (w == IPB_OFS_CAPTURE_DMA) begin
            reg_index = 3'h0;
        end else if (w == IPB_OFS_COMPARE_CAPT) begin
            reg_index = 3'h1;
        end else if (w == IPB_OFS_TIMER_DMA_CMP) begin
            reg_index = 3'h2;
        end else if (w == IPB_OFS_TIMER_TWOWIRE) begin
            reg_index = 3'h3;
        end else if (w == IPB_OFS_CAN_EXTINT_TMR) begin
            reg_index = 3'h4;
        end else begin
            reg_index = IPB_IDX_NONE;
        end
    endfunction : reg_index

    // ************************************************************
    // declarations
    // ************************************************************
    logic                  rst_meta;
    logic                  rst_n;
    ipb_wr_state_t         wr_state;
    ipb_wr_state_t         next_wr_state;
    ipb_rd_state_t         rd_state;
    ipb_rd_state_t         next_rd_state;
    logic                  aw_hold;
    logic [IPB_ADDR_W-1:0] aw_addr;
    logic                  w_hold;
    logic [15:0]           w_data;
    logic [1:0]            w_strb;
    logic                  aw_fire;
    logic                  w_fire;
    logic                  ar_fire;
    logic                  wr_commit;
    logic [2:0]            wr_sel;
    logic [2:0]            rd_sel;
    ipb_word_t             rd_word;
    logic [1:0]            bresp;
    ipb_rd_beat_t          rd_beat;
    ipb_bank_t             bank;

    // ************************************************************
    // reset release
    // ************************************************************
    // assert at once, release two clocks later so no register leaves
    // reset on a different edge from its neighbours
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ************************************************************
    // write channel
    // ************************************************************
    assign S_AXI_AWREADY_O = (wr_state == IPB_WR_COLLECT) && !aw_hold;
    assign S_AXI_WREADY_O  = (wr_state == IPB_WR_COLLECT) && !w_hold;
    assign S_AXI_BVALID_O  = (wr_state == IPB_WR_RESP);
    assign S_AXI_BRESP_O   = bresp;
    assign aw_fire         = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
    assign w_fire          = S_AXI_WVALID_I && S_AXI_WREADY_O;
    assign wr_commit       = (wr_state == IPB_WR_COLLECT) && aw_hold && w_hold;
    assign wr_sel          = reg_index(aw_addr);

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold <= 1'b0;
            aw_addr <= '0;
        end else if (aw_fire) begin
            aw_hold <= 1'b1;
            aw_addr <= S_AXI_AWADDR_I;
        end else if (wr_commit) begin
            aw_hold <= 1'b0;
        end
    end

    // only the low half of the data word holds register bits
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            w_hold <= 1'b0;
            w_data <= 16'h0000;
            w_strb <= 2'h0;
        end else if (w_fire) begin
            w_hold <= 1'b1;
            w_data <= S_AXI_WDATA_I[15:0];
            w_strb <= S_AXI_WSTRB_I[1:0];
        end else if (wr_commit) begin
            w_hold <= 1'b0;
        end
    end

    always_comb begin
        next_wr_state = wr_state;
        case (wr_state)
            IPB_WR_COLLECT: begin
                if (wr_commit) begin
                    next_wr_state = IPB_WR_RESP;
                end
            end
            IPB_WR_RESP: begin
                if (S_AXI_BREADY_I) begin
                    next_wr_state = IPB_WR_COLLECT;
                end
            end
            default: next_wr_state = IPB_WR_COLLECT;
        endcase
    end

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            wr_state <= IPB_WR_COLLECT;
            bresp    <= IPB_RESP_OKAY;
        end else begin
            wr_state <= next_wr_state;
            if (wr_commit) begin
                bresp <= (wr_sel == IPB_IDX_NONE) ? IPB_RESP_SLVERR : IPB_RESP_OKAY;
            end
        end
    end

    // ************************************************************
    // register bank
    // ************************************************************
    for (genvar r = 0; r < IPB_NREG; r++) begin : g_reg
        ipb_prio_reg #(
            .MASK  (IPB_MASK[r]),
            .RESET (IPB_RESET[r])
        ) u_reg (
            .clk_i   (CLK_I),
            .rst_n_i (rst_n),
            .wr_i    (wr_commit && (wr_sel == 3'(r))),
            .strb_i  (w_strb),
            .wdata_i (w_data),
            .value_o (bank[r])
        );
    end

    // ************************************************************
    // read channel
    // ************************************************************
    assign rd_sel          = reg_index(S_AXI_ARADDR_I);
    assign rd_word         = (rd_sel < 3'(IPB_NREG)) ? bank[rd_sel] : 16'h0000;
    assign S_AXI_ARREADY_O = (rd_state == IPB_RD_IDLE);
    assign S_AXI_RVALID_O  = (rd_state == IPB_RD_DATA);
    assign ar_fire         = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    assign S_AXI_RDATA_O   = rd_beat.data;
    assign S_AXI_RRESP_O   = rd_beat.resp;

    always_comb begin
        next_rd_state = rd_state;
        case (rd_state)
            IPB_RD_IDLE: begin
                if (ar_fire) begin
                    next_rd_state = IPB_RD_DATA;
                end
            end
            IPB_RD_DATA: begin
                if (S_AXI_RREADY_I) begin
                    next_rd_state = IPB_RD_IDLE;
                end
            end
            default: next_rd_state = IPB_RD_IDLE;
        endcase
    end

    // upper sixteen bits and every hole come back as zero
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            rd_state <= IPB_RD_IDLE;
            rd_beat  <= '0;
        end else begin
            rd_state <= next_rd_state;
            if (ar_fire) begin
                rd_beat.data <= {16'h0000, rd_word};
                rd_beat.resp <= (rd_sel == IPB_IDX_NONE) ? IPB_RESP_SLVERR : IPB_RESP_OKAY;
            end
        end
    end

    // ************************************************************
    // levels toward arbitration
    // ************************************************************
    // no extra stage: arbitration sees a write on the very next edge
    ipb_level_map u_map (
        .bank_i  (bank),
        .flag_i  (SRC_FLAG_I),
        .level_o (SRC_LEVEL_O),
        .req_o   (SRC_REQ_O)
    );

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!rst_n);

    logic [IPB_NSRC-1:0] lvl_nz;
    for (genvar s = 0; s < IPB_NSRC; s++) begin : g_nz
        assign lvl_nz[s] = |SRC_LEVEL_O[s];
    end

    property p_reset_bank;
        $rose(rst_n) |-> (bank[0] == 16'h4444) && (bank[2] == 16'h4404) && (bank[4] == 16'h4444);
    endproperty
    a_reset_bank: assert property (p_reset_bank) else $error("bank not at reset value");

    property p_reset_levels;
        $rose(rst_n) |-> (SRC_LEVEL_O[IPB_SRC_TIMER9] == 3'h4) && (SRC_LEVEL_O[IPB_SRC_CAPTURE5] == 3'h4);
    endproperty
    a_reset_levels: assert property (p_reset_levels) else $error("source not at level four");

    property p_holes_zero;
        S_AXI_RVALID_O |-> ((S_AXI_RDATA_O & ~{16'h0000, IPB_MASK_FULL}) == 32'h0);
    endproperty
    a_holes_zero: assert property (p_holes_zero) else $error("hole bit read as one");

    property p_mid_empty;
        bank[2][7:3] == 5'h00;
    endproperty
    a_mid_empty: assert property (p_mid_empty) else $error("third register bits 7-3 set");

    property p_write_next;
        wr_commit && (wr_sel == 3'h1) && (w_strb == 2'h3) |=>
            (bank[1] == ($past(w_data) & 16'h7777)) && (SRC_LEVEL_O[IPB_SRC_COMPARE7] == $past(w_data[14:12]));
    endproperty
    a_write_next: assert property (p_write_next) else $error("write not visible next cycle");

    property p_readback;
        ar_fire && (rd_sel == 3'h3) |=> (S_AXI_RDATA_O[15:0] == $past(bank[3])) && S_AXI_RVALID_O;
    endproperty
    a_readback: assert property (p_readback) else $error("read differs from stored value");

    property p_map_first;
        (SRC_LEVEL_O[IPB_SRC_CAPTURE5] == bank[0][14:12]) && (SRC_LEVEL_O[IPB_SRC_DMA3_DONE] == bank[0][2:0]);
    endproperty
    a_map_first: assert property (p_map_first) else $error("first register map wrong");

    property p_map_second;
        (SRC_LEVEL_O[IPB_SRC_COMPARE5] == bank[1][6:4]) && (SRC_LEVEL_O[IPB_SRC_CAPTURE6] == bank[1][2:0]);
    endproperty
    a_map_second: assert property (p_map_second) else $error("second register map wrong");

    property p_map_third;
        (SRC_LEVEL_O[IPB_SRC_DMA4_DONE] == bank[2][10:8]) && (SRC_LEVEL_O[IPB_SRC_COMPARE8] == bank[2][2:0]);
    endproperty
    a_map_third: assert property (p_map_third) else $error("third register map wrong");

    property p_map_fourth;
        (SRC_LEVEL_O[IPB_SRC_TWOWIRE2_SLAVE] == bank[3][6:4]) && (SRC_LEVEL_O[IPB_SRC_TIMER8] == bank[3][14:12]);
    endproperty
    a_map_fourth: assert property (p_map_fourth) else $error("fourth register map wrong");

    property p_map_fifth;
        (SRC_LEVEL_O[IPB_SRC_CAN2_RECEIVE] == bank[4][14:12]) && (SRC_LEVEL_O[IPB_SRC_TIMER9] == bank[4][2:0]);
    endproperty
    a_map_fifth: assert property (p_map_fifth) else $error("fifth register map wrong");

    property p_disabled_quiet;
        (SRC_REQ_O & ~lvl_nz) == '0;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled source requests");

    property p_level_passes;
        SRC_FLAG_I[IPB_SRC_TIMER6] && (SRC_LEVEL_O[IPB_SRC_TIMER6] >= 3'h1) |-> SRC_REQ_O[IPB_SRC_TIMER6];
    endproperty
    a_level_passes: assert property (p_level_passes) else $error("active level did not request");

    property p_write_answer;
        aw_fire && w_fire |=> wr_commit ##1 S_AXI_BVALID_O;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write answer late");

    property p_bresp_hold;
        S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold) else $error("write answer dropped");

    property p_unmapped;
        ar_fire && (rd_sel == IPB_IDX_NONE) |=> (S_AXI_RRESP_O == IPB_RESP_SLVERR) && (S_AXI_RDATA_O == 32'h0);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");

    property p_unmapped_write;
        wr_commit && (wr_sel == IPB_IDX_NONE) |=> $stable(bank);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write changed bank");

    c_same_cycle: cover property (aw_fire && w_fire);
    c_write_read: cover property (wr_commit ##[1:20] ar_fire);
    c_disabled: cover property (SRC_FLAG_I[IPB_SRC_EXTERNAL4] && !lvl_nz[IPB_SRC_EXTERNAL4]);
    c_bad_write: cover property (wr_commit && (wr_sel == IPB_IDX_NONE));

endmodule : ipb_bank_top

// ==== dv/ipb_bank_top_test.sv ====
// self-checking testbench for the interrupt priority bank
`timescale 1ns/1ps
module ipb_bank_top_test;
    import ipb_pkg::*;

    // ************************************************************
    // signals and design
    // ************************************************************
    logic                clk;
    logic                rst_n;
    logic [7:0]          awaddr, araddr;
    logic                awvalid, wvalid, bready, arvalid, rready;
    logic [31:0]         wdata, rdata;
    logic [3:0]          wstrb;
    logic                awready, wready, bvalid, arready, rvalid;
    logic [1:0]          bresp, rresp, resp;
    logic [IPB_NSRC-1:0] flag, req;
    ipb_levels_t         level;
    logic [15:0]         model [IPB_NREG];
    logic [31:0]         rd;
    int                  num_errors, comparisons;

    ipb_bank_top uut (
        .CLK_I           (clk),
        .RST_N_I         (rst_n),
        .S_AXI_AWADDR_I  (awaddr),
        .S_AXI_AWVALID_I (awvalid),
        .S_AXI_AWREADY_O (awready),
        .S_AXI_WDATA_I   (wdata),
        .S_AXI_WSTRB_I   (wstrb),
        .S_AXI_WVALID_I  (wvalid),
        .S_AXI_WREADY_O  (wready),
        .S_AXI_BRESP_O   (bresp),
        .S_AXI_BVALID_O  (bvalid),
        .S_AXI_BREADY_I  (bready),
        .S_AXI_ARADDR_I  (araddr),
        .S_AXI_ARVALID_I (arvalid),
        .S_AXI_ARREADY_O (arready),
        .S_AXI_RDATA_O   (rdata),
        .S_AXI_RRESP_O   (rresp),
        .S_AXI_RVALID_O  (rvalid),
        .S_AXI_RREADY_I  (rready),
        .SRC_FLAG_I      (flag),
        .SRC_LEVEL_O     (level),
        .SRC_REQ_O       (req)
    );

    always #5 clk = ~clk;

    // ************************************************************
    // checking and bus tasks
    // ************************************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // ready is looked at on the falling edge so the handshake edge is never raced
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        logic aw_hs, w_hs, b_hs;
        int   n;
        b_hs = 1'b0;
        n = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_hs && n < 50) begin
            @(negedge clk);
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            b_hs = bvalid;
            r = bresp;
            @(posedge clk);
            n++;
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        check("write handshake", 32'h1, {31'h0, b_hs});
        @(posedge clk);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_hs, r_hs;
        int   n;
        r_hs = 1'b0;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_hs && n < 50) begin
            @(negedge clk);
            ar_hs = arvalid && arready;
            r_hs = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            n++;
            if (ar_hs) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        check("read handshake", 32'h1, {31'h0, r_hs});
        @(posedge clk);
    endtask : axi_read

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s, input logic [15:0] m);
        logic [15:0] lane;
        lane = {{8{s[1]}}, {8{s[0]}}};
        return ((d[15:0] & lane) | (old & ~lane)) & m;
    endfunction : merge

    task automatic check_levels();
        logic [2:0] lv;
        @(negedge clk);
        for (int s = 0; s < IPB_NSRC; s++) begin
            lv = model[IPB_SRC_REG[s]][IPB_SRC_LSB[s] +: 3];
            check("source level", {29'h0, lv}, {29'h0, level[s]});
            check("source request", {31'h0, flag[s] && lv != 3'h0}, {31'h0, req[s]});
        end
        @(posedge clk);
    endtask : check_levels

    task automatic wr_reg(input int r, input logic [31:0] d, input logic [3:0] s);
        axi_write(8'(r * 4), d, s, resp);
        model[r] = merge(model[r], d, s, r == 2 ? 16'h7707 : 16'h7777);
        check("write response", 32'h0, {30'h0, resp});
        check_levels();
    endtask : wr_reg

    task automatic read_all();
        for (int r = 0; r < IPB_NREG; r++) begin
            axi_read(8'(r * 4), rd, resp);
            check("register word", {16'h0, model[r]}, rd);
            check("read response", 32'h0, {30'h0, resp});
        end
    endtask : read_all

    task automatic reset_check();
        model = '{16'h4444, 16'h4444, 16'h4404, 16'h4444, 16'h4444};
        read_all();
        check_levels();
    endtask : reset_check

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {awaddr, araddr, wdata, wstrb, flag} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        num_errors = 0;
        comparisons = 0;
        void'($urandom(32'h6d99));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        reset_check();
        $display("test reset values done");
        flag <= IPB_NSRC'($urandom);
        for (int l = 0; l < 8; l++) begin
            for (int r = 0; r < IPB_NREG; r++) wr_reg(r, {16'h0, {4{1'b0, 3'(l)}}}, 4'hF);
            read_all();
        end
        for (int r = 0; r < IPB_NREG; r++) wr_reg(r, 32'hFFFFFFFF, 4'hF);
        read_all();
        $display("test level walk done");
        repeat (60) begin
            flag <= IPB_NSRC'($urandom);
            wr_reg($urandom_range(0, 4), $urandom, 4'($urandom_range(0, 15)));
        end
        read_all();
        $display("test random writes done");
        axi_write(8'h14, 32'hFFFFFFFF, 4'hF, resp);
        check("unmapped write response", 32'h2, {30'h0, resp});
        axi_read(8'h14, rd, resp);
        check("unmapped read data", 32'h0, rd);
        check("unmapped read response", 32'h2, {30'h0, resp});
        // low address bits are ignored, so an unaligned address reads its word
        axi_read(8'h0B, rd, resp);
        check("unaligned read data", {16'h0, model[2]}, rd);
        read_all();
        $display("test unmapped access done");
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        reset_check();
        $display("test second reset done");
        complete_run();
    end

    // bounded by about forty times the expected length of the run (some 755 cycles)
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        complete_run();
    end

endmodule : ipb_bank_top_test
